// File: design/asq_sequencer.sv
// Behaviour
// [R1] scan list holds up to 512 entries of any analog channels, host loaded
// [R2] analog entries converted in turn, one microsecond per conversion
// [R3] after a scan restart at once or after a delay in 20.83 ns steps
// [R4] digital and counter inputs readable live by the host at any time
// [R5] once-per-scan mode captures digital and counters in first slot
// [R6] digital and counter capture uses no analog slot
// [R7] per-sample mode captures digital with every analog conversion
// [R8] per-sample mode still captures counters once per scan
// [R9] counters accumulate continuously regardless of capture or read
// [R10] each entry has own range of seven and single-ended or differential
// [R11] one oversampling count up to 16384 applies to all analog entries
// [R12] N oversamples take N microseconds and return their 16-bit average
// [R13] digital values are never averaged
// [R14] temperature entries add one oversampled cold-junction reading per scan
// [R15] autozero adds an extra shorted-input entry to each scan
// [R16] digital capture at scan start adds no scan time
// [R17] counters return 16 or 32 bits; digital returns 8, 16 or 24 bits
// [R18] every sample is 16 bits; 32-bit counts go low word then high word
// [R19] no digital samples during the delay between scans
// [R20] samples held in a one million sample buffer before transfer
// [R21] host programs the whole scan before starting; device then streams
// [R22] each counter has its own mode: totalize, pulse width or encoder
// [R23] samples leave in fixed scan-list order
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module asq_sequencer #(
    parameter int BUF_DEPTH = 1048576,
    parameter int BUF_AW    = 20
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             adc_start,
    output logic      [5:0]  adc_channel,
    output logic      [2:0]  adc_range,
    output logic             adc_single_ended_input,
    output logic             adc_differential_input,
    output logic             adc_cold_junction_reading,
    output logic             adc_autozero,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_data,
    input  wire logic [23:0] din_pins,
    input  wire logic [3:0]  cnt_pins,
    input  wire logic [3:0]  enc_b_pins,
    output logic             smp_valid,
    input  wire logic        smp_ready,
    output logic      [15:0] smp_data
);
    typedef enum logic [1:0] {ST_IDLE, ST_SLOT, ST_DELAY} asq_state_t;
    typedef enum logic [1:0] {PH_LIST, PH_CJC, PH_AZ} asq_phase_t;

    asq_state_t state;
    asq_phase_t phase;
    logic [3:0]  ctrl;
    logic [asq_pkg::OVS_EXP_W-1:0] ovs_exp;
    logic [asq_pkg::DLY_W-1:0] delay_val, dly_cnt;
    logic [asq_pkg::LEN_W-1:0] list_len;
    logic [asq_pkg::LIST_AW-1:0] list_ptr, idx;
    logic [2:0]  din_cfg;
    logic [15:0] cnt_cfg;
    logic        overflow, run_q;
    logic [asq_pkg::ENT_W-1:0] list_mem [asq_pkg::LIST_DEPTH];
    logic [asq_pkg::ENT_W-1:0] ent;
    logic [asq_pkg::SLOT_W-1:0] slot_cnt;
    logic [13:0] os_cnt;
    logic [asq_pkg::ACC_W-1:0] acc;
    logic [15:0] adc_q;
    logic        seen_tc;
    logic [asq_pkg::TB_ACC_W-1:0] tb_acc;
    logic        tb_tick;
    logic [23:0] din_s1, din_s2;
    logic [3:0]  cnt_s1, cnt_s2, cnt_s3, encb_s1, encb_s2;
    logic [31:0] cnt_val [asq_pkg::NCNT];
    logic [23:0] snap_din;
    logic [31:0] snap_cnt [asq_pkg::NCNT];
    logic        em_busy, em_dig, em_cnt;
    logic [asq_pkg::EM_W-1:0] em_idx;
    logic [15:0] em_word;
    logic        em_en;
    logic [15:0] mem [BUF_DEPTH];
    logic [BUF_AW-1:0] wr_ptr, rd_ptr;
    logic [BUF_AW:0]   level;
    logic        buf_we, buf_full, buf_take, an_we;
    logic [15:0] buf_wdata;
    logic        run_rise, slot_end, conv_last, first_slot, cap_now;
    logic [13:0] os_last;

    assign run_rise   = ctrl[asq_pkg::CTRL_RUN] & ~run_q & (list_len != '0);
    assign slot_end   = (state == ST_SLOT) && (slot_cnt == asq_pkg::SLOT_LAST);
    assign os_last    = 14'((32'h1 << ovs_exp) - 32'h1);
    assign conv_last  = (os_cnt == os_last);
    assign first_slot = (phase == PH_LIST) && (idx == '0) && (os_cnt == '0);
    assign cap_now    = (state == ST_SLOT) && (slot_cnt == asq_pkg::SLOT_START);
    assign an_we      = slot_end && conv_last;

    ////////////////////////////////////////////////////////////////////////////////
    // register port
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl      <= '0;
            ovs_exp   <= '0;
            delay_val <= '0;
            list_len  <= '0;
            list_ptr  <= '0;
            din_cfg   <= '0;
            cnt_cfg   <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                asq_pkg::REG_CTRL:     ctrl <= reg_wdata[3:0];
                // clamp keeps the average shift inside 16384 oversamples
                asq_pkg::REG_OVS:      ovs_exp <= (reg_wdata[3:0] > asq_pkg::OVS_EXP_MAX) ?
                                                  asq_pkg::OVS_EXP_MAX : reg_wdata[3:0];
                asq_pkg::REG_DELAY_LO: delay_val[31:0] <= reg_wdata;
                asq_pkg::REG_DELAY_HI: delay_val[asq_pkg::DLY_W-1:32] <= reg_wdata[asq_pkg::DLY_W-33:0];
                asq_pkg::REG_LIST_LEN: list_len <= (reg_wdata[asq_pkg::LEN_W-1:0] > asq_pkg::LEN_W'(asq_pkg::LIST_DEPTH)) ?
                                                   asq_pkg::LEN_W'(asq_pkg::LIST_DEPTH) : reg_wdata[asq_pkg::LEN_W-1:0];
                asq_pkg::REG_LIST_PTR: list_ptr <= reg_wdata[asq_pkg::LIST_AW-1:0];
                asq_pkg::REG_LIST_DATA: list_ptr <= list_ptr + 1'b1;
                asq_pkg::REG_DIN_CFG:  din_cfg <= reg_wdata[2:0];
                asq_pkg::REG_CNT_CFG:  cnt_cfg <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // [R1] list loading
    always_ff @(posedge mclk) begin
        if (reg_wr && reg_addr == asq_pkg::REG_LIST_DATA) begin
            list_mem[list_ptr] <= reg_wdata[asq_pkg::ENT_W-1:0];
        end
        ent <= list_mem[idx];
    end

    // [R4] live read-back
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                asq_pkg::REG_CTRL:      reg_rdata <= {28'h0, ctrl};
                asq_pkg::REG_STATUS:    reg_rdata <= {29'h0, state == ST_DELAY, overflow, state != ST_IDLE};
                asq_pkg::REG_OVS:       reg_rdata <= {28'h0, ovs_exp};
                asq_pkg::REG_DELAY_LO:  reg_rdata <= delay_val[31:0];
                asq_pkg::REG_DELAY_HI:  reg_rdata <= 32'(delay_val[asq_pkg::DLY_W-1:32]);
                asq_pkg::REG_LIST_LEN:  reg_rdata <= 32'(list_len);
                asq_pkg::REG_LIST_PTR:  reg_rdata <= 32'(list_ptr);
                asq_pkg::REG_DIN_CFG:   reg_rdata <= {29'h0, din_cfg};
                asq_pkg::REG_CNT_CFG:   reg_rdata <= {16'h0, cnt_cfg};
                asq_pkg::REG_DIN_NOW:   reg_rdata <= {8'h0, din_s2};
                asq_pkg::REG_BUF_LEVEL: reg_rdata <= 32'(level);
                asq_pkg::REG_CNT_NOW0:  reg_rdata <= cnt_val[0];
                asq_pkg::REG_CNT_NOW0 + asq_pkg::CNT_NOW_STEP: reg_rdata <= cnt_val[1];
                asq_pkg::REG_CNT_NOW0 + 2 * asq_pkg::CNT_NOW_STEP: reg_rdata <= cnt_val[2];
                asq_pkg::REG_CNT_NOW0 + 3 * asq_pkg::CNT_NOW_STEP: reg_rdata <= cnt_val[3];
                default:                reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // overflow: a drop in the same cycle as the clear keeps the flag
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            overflow <= 1'b0;
        end else if (buf_we && buf_full) begin
            overflow <= 1'b1;
        end else if (reg_wr && reg_addr == asq_pkg::REG_STATUS && reg_wdata[asq_pkg::STAT_OVERFLOW]) begin
            overflow <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            din_s1  <= '0;
            din_s2  <= '0;
            cnt_s1  <= '0;
            cnt_s2  <= '0;
            cnt_s3  <= '0;
            encb_s1 <= '0;
            encb_s2 <= '0;
        end else begin
            din_s1  <= din_pins;
            din_s2  <= din_s1;
            cnt_s1  <= cnt_pins;
            cnt_s2  <= cnt_s1;
            cnt_s3  <= cnt_s2;
            encb_s1 <= enc_b_pins;
            encb_s2 <= encb_s1;
        end
    end

    // [R9] [R22] free running counters
    for (genvar i = 0; i < asq_pkg::NCNT; i++) begin : g_cnt
        logic [1:0] mode;
        logic       rise;
        assign mode = cnt_cfg[8 + 2*i +: 2];
        assign rise = cnt_s2[i] & ~cnt_s3[i];
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                cnt_val[i] <= '0;
            end else if (mode == asq_pkg::CM_WIDTH) begin
                // width restarts on each rising edge, counts clocks while high
                cnt_val[i] <= rise ? 32'h1 : (cnt_s2[i] ? cnt_val[i] + 32'h1 : cnt_val[i]);
            end else if (mode == asq_pkg::CM_ENC) begin
                if (rise) begin
                    cnt_val[i] <= encb_s2[i] ? cnt_val[i] - 32'h1 : cnt_val[i] + 32'h1;
                end
            end else if (rise) begin
                cnt_val[i] <= cnt_val[i] + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timebase of 20.83 ns steps from the 8 ns clock by fractional accumulation
    always_ff @(posedge mclk) begin
        if (!rstn || state != ST_DELAY) begin
            tb_acc  <= '0;
            tb_tick <= 1'b0;
        end else if (tb_acc + asq_pkg::TB_CLK_10PS >= asq_pkg::TB_STEP_10PS) begin
            tb_acc  <= tb_acc + asq_pkg::TB_CLK_10PS - asq_pkg::TB_STEP_10PS;
            tb_tick <= 1'b1;
        end else begin
            tb_acc  <= tb_acc + asq_pkg::TB_CLK_10PS;
            tb_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scan sequencer
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state    <= ST_IDLE;
            phase    <= PH_LIST;
            idx      <= '0;
            slot_cnt <= '0;
            os_cnt   <= '0;
            dly_cnt  <= '0;
            seen_tc  <= 1'b0;
            run_q    <= 1'b0;
        end else begin
            run_q <= ctrl[asq_pkg::CTRL_RUN];
            if (!ctrl[asq_pkg::CTRL_RUN]) begin
                state <= ST_IDLE;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        // [R21] starts only on the run edge with a loaded list
                        if (run_rise) begin
                            state    <= ST_SLOT;
                            phase    <= PH_LIST;
                            idx      <= '0;
                            slot_cnt <= '0;
                            os_cnt   <= '0;
                            seen_tc  <= 1'b0;
                        end
                    end
                    ST_SLOT: begin
                        // [R2] one microsecond per conversion
                        slot_cnt <= slot_end ? '0 : slot_cnt + 1'b1;
                        if (cap_now && phase == PH_LIST && ent[asq_pkg::ENT_TC]) begin
                            seen_tc <= 1'b1;
                        end
                        if (slot_end) begin
                            // [R11] [R12] same oversample count for every analog entry
                            os_cnt <= conv_last ? '0 : os_cnt + 1'b1;
                            if (conv_last) begin
                                // [R23] list order, then cold junction, then autozero
                                if (phase == PH_LIST && 10'(idx) != list_len - 1'b1) begin
                                    idx <= idx + 1'b1;
                                // [R14] cold junction once per scan with temperature entries
                                end else if (phase == PH_LIST && (seen_tc || ent[asq_pkg::ENT_TC])) begin
                                    phase <= PH_CJC;
                                // [R15] autozero lengthens the scan
                                end else if (phase != PH_AZ && ctrl[asq_pkg::CTRL_AUTOZERO]) begin
                                    phase <= PH_AZ;
                                end else begin
                                    phase   <= PH_LIST;
                                    idx     <= '0;
                                    seen_tc <= 1'b0;
                                    // [R3] immediate restart or delay
                                    if (ctrl[asq_pkg::CTRL_DELAY_EN] && delay_val != '0) begin
                                        state   <= ST_DELAY;
                                        dly_cnt <= delay_val;
                                    end
                                end
                            end
                        end
                    end
                    ST_DELAY: begin
                        // [R3] delay counted in timebase steps
                        if (tb_tick) begin
                            dly_cnt <= dly_cnt - 1'b1;
                            if (dly_cnt == 42'h1) begin
                                state    <= ST_SLOT;
                                slot_cnt <= '0;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // [R10] per-entry range and input type to the converter
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            adc_start                 <= 1'b0;
            adc_channel               <= '0;
            adc_range                 <= '0;
            adc_single_ended_input    <= 1'b1;
            adc_differential_input    <= 1'b0;
            adc_cold_junction_reading <= 1'b0;
            adc_autozero              <= 1'b0;
        end else begin
            adc_start <= cap_now;
            if (cap_now) begin
                adc_channel               <= ent[asq_pkg::ENT_CH_LO +: asq_pkg::ENT_CH_W];
                adc_range                 <= (ent[asq_pkg::ENT_RNG_LO +: asq_pkg::ENT_RNG_W] > asq_pkg::RANGE_MAX) ?
                                             asq_pkg::RANGE_MAX : ent[asq_pkg::ENT_RNG_LO +: asq_pkg::ENT_RNG_W];
                adc_single_ended_input    <= ~ent[asq_pkg::ENT_DIFF];
                adc_differential_input    <= ent[asq_pkg::ENT_DIFF];
                adc_cold_junction_reading <= (phase == PH_CJC);
                adc_autozero              <= (phase == PH_AZ);
            end
        end
    end

    // [R12] sum of N conversions, averaged by shift
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            adc_q <= '0;
            acc   <= '0;
        end else begin
            if (adc_done) begin
                adc_q <= adc_data;
            end
            if (slot_end) begin
                acc <= conv_last ? '0 : acc + asq_pkg::ACC_W'(adc_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // [R5] [R6] [R7] [R8] [R16] [R19] capture at slot start, beside the conversion
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            em_busy  <= 1'b0;
            em_dig   <= 1'b0;
            em_cnt   <= 1'b0;
            em_idx   <= '0;
            snap_din <= '0;
        end else if (cap_now && (first_slot || ctrl[asq_pkg::CTRL_PER_SAMPLE])) begin
            em_busy  <= 1'b1;
            em_idx   <= '0;
            em_dig   <= din_cfg[asq_pkg::DIN_EN];
            em_cnt   <= first_slot;
            snap_din <= din_s2;
        end else if (em_busy) begin
            em_idx  <= em_idx + 1'b1;
            em_busy <= (em_idx != asq_pkg::EM_LAST);
        end
    end

    for (genvar i = 0; i < asq_pkg::NCNT; i++) begin : g_snap
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                snap_cnt[i] <= '0;
            end else if (cap_now && first_slot) begin
                snap_cnt[i] <= cnt_val[i];
            end
        end
    end

    // [R13] [R17] [R18] raw 16-bit words, low word before high word
    always_comb begin
        em_word = '0;
        em_en   = 1'b0;
        if (em_idx == '0) begin
            em_en   = em_dig;
            em_word = (din_cfg[1:0] == asq_pkg::DIN_W8) ? {8'h00, snap_din[7:0]} : snap_din[15:0];
        end else if (em_idx == 4'h1) begin
            em_en   = em_dig && din_cfg[1:0] == asq_pkg::DIN_W24;
            em_word = {8'h00, snap_din[23:16]};
        end else begin
            for (int i = 0; i < asq_pkg::NCNT; i++) begin
                if (em_idx == asq_pkg::EM_W'(2 + 2*i)) begin
                    em_en   = em_cnt && cnt_cfg[i];
                    em_word = snap_cnt[i][15:0];
                end else if (em_idx == asq_pkg::EM_W'(3 + 2*i)) begin
                    em_en   = em_cnt && cnt_cfg[i] && cnt_cfg[4+i];
                    em_word = snap_cnt[i][31:16];
                end
            end
        end
    end

    // emitter finishes long before the slot end, so the two writers never meet
    assign buf_we    = an_we | (em_busy & em_en);
    assign buf_wdata = an_we ? 16'((acc + asq_pkg::ACC_W'(adc_q)) >> ovs_exp) : em_word;

    ////////////////////////////////////////////////////////////////////////////////
    // [R20] sample buffer; a full buffer drops new samples and flags overflow
    assign buf_full = (level == (BUF_AW+1)'(BUF_DEPTH));
    assign buf_take = (level != '0) && (!smp_valid || smp_ready);

    always_ff @(posedge mclk) begin
        if (buf_we && !buf_full) begin
            mem[wr_ptr] <= buf_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            level     <= '0;
            smp_valid <= 1'b0;
            smp_data  <= '0;
        end else begin
            if (buf_we && !buf_full) begin
                wr_ptr <= (wr_ptr == BUF_AW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (buf_take) begin
                rd_ptr   <= (rd_ptr == BUF_AW'(BUF_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
                smp_data <= mem[rd_ptr];
            end
            if (buf_take) begin
                smp_valid <= 1'b1;
            end else if (smp_ready) begin
                smp_valid <= 1'b0;
            end
            level <= level + (BUF_AW+1)'(buf_we && !buf_full) - (BUF_AW+1)'(buf_take);
        end
    end
endmodule
`default_nettype wire

// File: design/asq_pkg.sv
`default_nettype none
package asq_pkg;
    // register byte addresses
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_OVS       = 8'h08;
    localparam logic [7:0] REG_DELAY_LO  = 8'h0c;
    localparam logic [7:0] REG_DELAY_HI  = 8'h10;
    localparam logic [7:0] REG_LIST_LEN  = 8'h14;
    localparam logic [7:0] REG_LIST_PTR  = 8'h18;
    localparam logic [7:0] REG_LIST_DATA = 8'h1c;
    localparam logic [7:0] REG_DIN_CFG   = 8'h20;
    localparam logic [7:0] REG_CNT_CFG   = 8'h24;
    localparam logic [7:0] REG_DIN_NOW   = 8'h28;
    localparam logic [7:0] REG_CNT_NOW0  = 8'h2c;
    localparam logic [7:0] REG_BUF_LEVEL = 8'h3c;
    localparam logic [7:0] CNT_NOW_STEP  = 8'h04;

    // control and status bits
    localparam int CTRL_RUN        = 0;
    localparam int CTRL_PER_SAMPLE = 1;
    localparam int CTRL_AUTOZERO   = 2;
    localparam int CTRL_DELAY_EN   = 3;
    localparam int STAT_BUSY       = 0;
    localparam int STAT_OVERFLOW   = 1;
    localparam int STAT_IN_DELAY   = 2;
    localparam int DIN_EN          = 2;

    // digital width codes
    localparam logic [1:0] DIN_W8  = 2'h0;
    localparam logic [1:0] DIN_W16 = 2'h1;
    localparam logic [1:0] DIN_W24 = 2'h2;

    // counter measurement modes
    localparam logic [1:0] CM_TOTAL = 2'h0;
    localparam logic [1:0] CM_WIDTH = 2'h1;
    localparam logic [1:0] CM_ENC   = 2'h2;

    // scan entry layout
    localparam int ENT_W      = 11;
    localparam int ENT_CH_LO  = 0;
    localparam int ENT_CH_W   = 6;
    localparam int ENT_RNG_LO = 6;
    localparam int ENT_RNG_W  = 3;
    localparam int ENT_DIFF   = 9;
    localparam int ENT_TC     = 10;
    localparam logic [ENT_RNG_W-1:0] RANGE_MAX = 3'h6;

    localparam int LIST_DEPTH = 512;
    localparam int LIST_AW    = 9;
    localparam int LEN_W      = 10;
    localparam int OVS_EXP_W  = 4;
    localparam logic [OVS_EXP_W-1:0] OVS_EXP_MAX = 4'he;
    localparam int ACC_W      = 30;
    localparam int DLY_W      = 42;
    localparam int NCNT       = 4;
    localparam int DIN_PINS   = 24;

    // timing: clock and slot in ns, timebase in units of 10 ps
    localparam int CLK_NS     = 8;
    localparam int SLOT_NS    = 1000;
    localparam int SLOT_CYC   = (SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOT_W     = 7;
    localparam logic [SLOT_W-1:0] SLOT_LAST  = SLOT_W'(SLOT_CYC - 1);
    localparam logic [SLOT_W-1:0] SLOT_START = 7'h01;
    localparam int TB_ACC_W   = 12;
    localparam logic [TB_ACC_W-1:0] TB_CLK_10PS  = TB_ACC_W'(CLK_NS * 100);
    localparam logic [TB_ACC_W-1:0] TB_STEP_10PS = 12'h823;

    // emitter word slots: two digital words, then low/high per counter
    localparam int EM_WORDS = 2 + 2 * NCNT;
    localparam int EM_W     = 4;
    localparam logic [EM_W-1:0] EM_LAST = EM_W'(EM_WORDS - 1);
endpackage
`default_nettype wire

// File: verification/asq_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module asq_adc_model (
    input  wire logic       mclk,
    input  wire logic       adc_start,
    input  wire logic [5:0] adc_channel,
    output logic            adc_done = 1'b0,
    output logic     [15:0] adc_data = 16'h0
);
    logic [3:0] dly = 4'h0;
    logic       tg  = 1'b0;
    always @(posedge mclk) begin
        adc_done <= 1'b0;
        if (adc_start) begin
            dly <= 4'ha;
        end else if (dly != 4'h0) begin
            dly <= dly - 4'h1;
            if (dly == 4'h1) begin
                adc_done <= 1'b1;
                tg <= ~tg;
                // every second sample reads two higher
                adc_data <= {10'h0, adc_channel} + (tg ? 16'h2 : 16'h0);
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/asq_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module asq_monitor (
    input wire logic mclk, rstn, reg_rd, adc_start, smp_valid, smp_ready,
    input wire logic adc_single_ended_input, adc_differential_input,
    input wire logic adc_cold_junction_reading, adc_autozero,
    input wire logic [31:0] reg_rdata,
    input wire logic [5:0] adc_channel,
    input wire logic [2:0] adc_range,
    input wire logic [15:0] smp_data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_quiet;
        !adc_start [*8];
    endsequence
    a_start_pulse: assert property (adc_start |=> s_quiet) else $error("start too close");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata");
    a_range_legal: assert property (adc_range <= 3'h6) else $error("range");
    a_mode_excl: assert property (adc_single_ended_input != adc_differential_input) else $error("mode");
    a_fields_hold: assert property (!adc_start |-> $stable(adc_channel) && $stable(adc_range))
        else $error("fields moved");
    a_extra_excl: assert property (!(adc_cold_junction_reading && adc_autozero)) else $error("flags");
    a_smp_hold: assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
        else $error("sample dropped");
    a_smp_fall: assert property ($fell(smp_valid) |-> $past(smp_ready)) else $error("valid fell");
endmodule
bind asq_sequencer asq_monitor mon_u (.mclk, .rstn, .reg_rd, .adc_start, .smp_valid, .smp_ready,
    .adc_single_ended_input, .adc_differential_input, .adc_cold_junction_reading, .adc_autozero,
    .reg_rdata, .adc_channel, .adc_range, .smp_data);
`default_nettype wire

// File: verification/acquisition_scan_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module acquisition_scan_sequencer_tb;
    logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, smp_ready = 0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic adc_start, adc_done, smp_valid, adc_single_ended_input, adc_differential_input;
    logic adc_cold_junction_reading, adc_autozero;
    logic [5:0] adc_channel;
    logic [2:0] adc_range;
    logic [15:0] adc_data, smp_data;
    int errors = 0, n_compared = 0, c;
    always #4 mclk = ~mclk;
    asq_sequencer #(.BUF_DEPTH(16), .BUF_AW(4)) dut_u (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .adc_start, .adc_channel, .adc_range, .adc_single_ended_input,
        .adc_differential_input, .adc_cold_junction_reading, .adc_autozero, .adc_done, .adc_data,
        .din_pins(24'h3c5aa5), .cnt_pins(4'h0), .enc_b_pins(4'h0), .smp_valid, .smp_ready, .smp_data);
    asq_adc_model adc_u (.mclk, .adc_start, .adc_channel, .adc_done, .adc_data);
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk) reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk) reg_rd <= 1'b0;
        @(negedge mclk) chk(reg_rdata, e);
    endtask
    task nxt;
        c = 0;
        do begin @(negedge mclk); c++; end while (!adc_start && c < 2000);
        if (c >= 2000) begin errors++; report_and_stop; end
    endtask
    task get(input logic [15:0] e);
        c = 0;
        do begin @(negedge mclk); c++; end while (!smp_valid && c < 2000);
        if (c >= 2000) begin errors++; report_and_stop; end
        chk(smp_data, e);
        @(posedge mclk) smp_ready <= 1'b1;
        @(posedge mclk) smp_ready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        chk(adc_single_ended_input, 1'b1);
        wr(asq_pkg::REG_OVS, 32'hf);
        rd(asq_pkg::REG_OVS, 32'he);
        rd(asq_pkg::REG_DIN_NOW, 32'h3c5aa5);
        rd(8'h40, 32'h0);
    endtask
    task t_scan;
        wr(asq_pkg::REG_LIST_LEN, 32'h2);
        wr(asq_pkg::REG_LIST_PTR, 32'h0);
        wr(asq_pkg::REG_LIST_DATA, 32'h3c5);
        wr(asq_pkg::REG_LIST_DATA, 32'h42);
        wr(asq_pkg::REG_DIN_CFG, 32'h5);
        wr(asq_pkg::REG_CNT_CFG, 32'h1);
        wr(asq_pkg::REG_OVS, 32'h0);
        wr(asq_pkg::REG_DELAY_LO, 32'hffff);
        wr(asq_pkg::REG_CTRL, 32'hd);
        nxt;
        chk({adc_channel, adc_range, adc_differential_input}, {6'h5, 3'h6, 1'b1});
        nxt;
        chk(c, 125);
        chk({adc_channel, adc_single_ended_input}, {6'h2, 1'b1});
        get(16'h5aa5);
        get(16'h0);
        get(16'h5);
        get(16'h4);
        chk(adc_autozero, 1'b1);
        get(16'h2);
        wr(asq_pkg::REG_CTRL, 32'h0);
    endtask
    task t_ps;
        wr(asq_pkg::REG_LIST_LEN, 32'h1);
        wr(asq_pkg::REG_OVS, 32'h1);
        wr(asq_pkg::REG_CTRL, 32'hb);
        get(16'h5aa5);
        get(16'h0);
        get(16'h5aa5);
        get(16'h6);
        repeat (300) @(negedge mclk) if (smp_valid) chk(smp_valid, 1'b0);
        wr(asq_pkg::REG_CTRL, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        t_regs;
        t_scan;
        t_ps;
        report_and_stop;
    end
endmodule
`default_nettype wire
